// ### rtl/prtd_decoder.sv
// Paging message layer decode: vector acceptance, time words, characters
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "prtd_defs.svh"
module prtd_decoder #(
  parameter longint unsigned FRAG_CYCLES = `PRTD_FRAG_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Frame 0 sync leading edge, from the frame timing logic
  input  wire logic        frame0_sync
);
  // Whole-module state
  typedef struct packed {
    logic              aw_hold;      // Address taken, data pending
    logic              w_hold;       // Data taken, address pending
    logic [7:0]        aw;           // Captured write address
    logic [31:0]       wd;           // Captured write data
    logic [3:0]        ws;           // Captured strobes
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              awrdy;        // Registered ready outputs
    logic              wrdy;
    logic              arrdy;
    logic              any_phase;    // Addressing scheme select
    logic              alt_num;      // Alternate numeric set
    prtd_pkg::prtd_rate_e rate;      // Current frame rate
    logic [16:0]       word;         // {type, payload} last written
    logic [4:0]        vec;          // {vector, subtype} last written
    logic              vec_ok;       // Vector accepted
    logic [2:0]        pend_coarse;  // Time word awaiting sync
    logic [5:0]        pend_min;
    logic [4:0]        pend_hour;
    logic              pend_valid;
    logic [2:0]        coarse;       // Committed local time
    logic [5:0]        minute;
    logic [4:0]        hour;
    logic              time_valid;
    logic [2:0]        fine;         // Fine seconds
    logic              dst;          // Daylight-saving flag
    logic [4:0]        zone;         // Zone code
    logic              zone_ok;      // System word marker matched
    logic [3:0]        num_code;     // Numeric code written
    logic [6:0]        alpha_code;   // Alpha code written
    logic              frag_live;    // Reassembly alive
    logic [33:0]       frag_cnt;     // Cycles since last fragment
  } prtd_state_s;

  prtd_state_s st;
  prtd_state_s next_st;

  logic       sync_q1;  // Synchroniser first stage
  logic       sync_q2;  // Synchroniser second stage
  logic       sync_q3;  // Edge detector history
  logic [7:0] glyph;
  logic       is_ctrl;

  // Vector acceptance under current capabilities
  function automatic logic vec_accept(input logic [4:0] v,
                                      input logic any_ph);
    logic [2:0] code;
    code = v[4:2];
    if (code == `PRTD_VEC_ALPHA || code == `PRTD_VEC_NUM ||
        code == `PRTD_VEC_NUMSP || code == `PRTD_VEC_NUMNS)
      return 1'b1;
    else if (code == `PRTD_VEC_SHORT)
      return v[1:0] == 2'b00;
    else if (code == `PRTD_VEC_INSTR)
      return any_ph && (v[1:0] == 2'b00);
    else
      return 1'b0;
  endfunction

  // Numeric code to ASCII, standard or alternate set
  function automatic logic [7:0] num_char(input logic [3:0] c,
                                          input logic alt);
    logic [7:0] r;
    r = 8'h3F;
    if (c <= 4'h9) r = 8'h30 + {4'h0, c};
    else if (c == 4'hC) r = 8'h20;
    else if (alt) begin
      if (c == 4'hA) r = 8'h41;
      else if (c == 4'hB) r = 8'h42;
      else r = 8'h43 + {4'h0, c - 4'hD};
    end else begin
      if (c == 4'hA) r = 8'h3F;            // Spare
      else if (c == 4'hB) r = 8'h55;
      else if (c == 4'hD) r = 8'h2D;
      else if (c == 4'hE) r = 8'h5D;
      else r = 8'h5B;
    end
    return r;
  endfunction

  // Zone code to signed quarter-hour offset; reserved code gives 8'h80
  function automatic logic [7:0] zone_qh(input logic [4:0] z);
    logic [7:0] q;
    q = 8'h00;
    if (z <= 5'h0C) q = {1'b0, z, 2'b00};
    else if (z == 5'h0D) q = 8'h0E;
    else if (z == 5'h0E) q = 8'h12;
    else if (z == 5'h0F) q = 8'h16;
    else if (z == 5'h10) q = 8'h80;              // Reserved
    else if (z == 5'h11) q = 8'h17;
    else if (z == 5'h12) q = 8'h1A;
    else if (z == 5'h13) q = 8'h26;
    else if (z == 5'h14) q = 8'hF2;              // -0330
    else q = 8'h00 - {1'b0, 5'h1F - z + 5'h01, 2'b00};
    return q;
  endfunction

  // Registered attribute lookup for alphanumeric codes
  prtd_char_rom u_rom (
    .aclk    (aclk),
    .code    (st.alpha_code),
    .glyph   (glyph),
    .is_ctrl (is_ctrl)
  );

  // Two-stage synchroniser for the frame 0 sync edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q1 <= 1'b0;
      sync_q2 <= 1'b0;
      sync_q3 <= 1'b0;
    end else begin
      sync_q1 <= frame0_sync;
      sync_q2 <= sync_q1;
      sync_q3 <= sync_q2;
    end
  end

  // Next-state logic
  always_comb begin
    logic        wr_go;
    logic [7:0]  ra;
    logic [31:0] rd;
    logic        hit;
    next_st = st;
    wr_go   = 1'b0;
    ra      = s_axi_araddr;
    rd      = 32'h0000_0000;
    hit     = 1'b1;
    // Capture address and data in either order
    if (s_axi_awvalid && st.awrdy) begin
      next_st.aw_hold = 1'b1;
      next_st.aw      = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wrdy) begin
      next_st.w_hold = 1'b1;
      next_st.wd     = s_axi_wdata;
      next_st.ws     = s_axi_wstrb;
    end
    if (st.aw_hold && st.w_hold) begin
      wr_go          = 1'b1;
      next_st.aw_hold = 1'b0;
      next_st.w_hold  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = 2'b00;
    end
    if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
    // Commit before the writes, so a word written now stays pending
    if (sync_q2 && !sync_q3 && st.pend_valid) begin
      next_st.coarse     = st.pend_coarse;
      next_st.minute     = st.pend_min;
      next_st.hour       = st.pend_hour;
      next_st.time_valid = 1'b1;
      next_st.pend_valid = 1'b0;
    end
    // Fragment hold timer; a fresh fragment below wins over expiry
    if (st.frag_live) begin
      if (st.frag_cnt >= 34'(FRAG_CYCLES - 64'h1))
        next_st.frag_live = 1'b0;
      else
        next_st.frag_cnt = st.frag_cnt + 34'h1;
    end
    // Register writes
    if (wr_go) begin
      if (st.aw == `PRTD_REG_CTRL) begin
        if (st.ws[0]) begin
          next_st.any_phase = st.wd[`PRTD_CTRL_ANYPH];
          next_st.alt_num   = st.wd[`PRTD_CTRL_ALTNUM];
          next_st.rate = prtd_pkg::prtd_rate_e'(
            st.wd[`PRTD_CTRL_RATE_LO +: 2]);
          if (st.wd[`PRTD_CTRL_FRAG]) begin
            next_st.frag_live = 1'b1;
            next_st.frag_cnt  = 34'h0;
          end
        end
      end else if (st.aw == `PRTD_REG_WORD) begin
        // Type sits above the 14 payload bits, so the two never overlap
        next_st.word = st.wd[16:0];
        if (st.wd[16:14] == `PRTD_TYPE_TIME) begin
          next_st.pend_coarse = st.wd[13:11];
          next_st.pend_min    = st.wd[10:5];
          next_st.pend_hour   = st.wd[4:0];
          next_st.pend_valid  = 1'b1;
        end else if (st.wd[16:14] == `PRTD_TYPE_SYS) begin
          if (st.wd[3:1] == `PRTD_SYS_MARK) begin
            next_st.fine    = st.wd[13:11];
            next_st.dst     = st.wd[9];
            next_st.zone    = st.wd[8:4];
            next_st.zone_ok = 1'b1;
          end else begin
            next_st.zone_ok = 1'b0;
          end
        end
      end else if (st.aw == `PRTD_REG_VECTOR) begin
        next_st.vec    = st.wd[4:0];
      end else if (st.aw == `PRTD_REG_CHAR) begin
        next_st.num_code   = st.wd[3:0];
        next_st.alpha_code = st.wd[14:8];
      end
    end
    // Read channel
    if (s_axi_arvalid && st.arrdy) begin
      if (ra == `PRTD_REG_CTRL)
        rd = {26'h0, st.frag_live, 1'b0, st.rate, st.alt_num,
              st.any_phase};
      else if (ra == `PRTD_REG_WORD) rd = {15'h0, st.word};
      else if (ra == `PRTD_REG_VECTOR)
        rd = {26'h0, st.vec_ok, st.vec};
      else if (ra == `PRTD_REG_TIME)
        // Seconds in sixty-fourths: coarse*8 + fine
        rd = {7'h0, st.time_valid, 2'h0, {st.coarse, st.fine},
              2'h0, st.minute, 3'h0, st.hour};
      else if (ra == `PRTD_REG_ZONE)
        rd = {16'h0, zone_qh(st.zone), st.zone_ok, st.dst, 1'b0,
              st.zone};
      else if (ra == `PRTD_REG_CHAR)
        rd = {15'h0, is_ctrl, glyph,
              num_char(st.num_code, st.alt_num)};
      else if (ra == `PRTD_REG_STATUS)
        rd = {30'h0, st.pend_valid, st.time_valid};
      else if (ra == `PRTD_REG_FRAG) rd = st.frag_cnt[31:0];
      else hit = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd;
      next_st.rresp  = hit ? 2'b00 : 2'b10;
    end
    if (st.rvalid && s_axi_rready) next_st.rvalid = 1'b0;
    // Acceptance follows the current addressing scheme
    next_st.vec_ok = vec_accept(next_st.vec, next_st.any_phase);
    // Readys from flops, matching the state that they guard
    next_st.awrdy = !next_st.aw_hold && !next_st.bvalid;
    next_st.wrdy  = !next_st.w_hold && !next_st.bvalid;
    next_st.arrdy = !next_st.rvalid;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Bus outputs straight from flops
  assign s_axi_awready = st.awrdy;
  assign s_axi_wready  = st.wrdy;
  assign s_axi_arready = st.arrdy;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  // Checks share one clock and reset
  default clocking cb_chk @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_time_commit: assert property (
    (sync_q2 && !sync_q3 && st.pend_valid) |=>
      st.time_valid && st.minute == $past(st.pend_min))
    else $error("time not committed on sync");
  chk_instr_gate: assert property (
    (st.vec[4:2] == `PRTD_VEC_INSTR && !st.any_phase) |-> !st.vec_ok)
    else $error("instruction vector accepted single phase");
  chk_short_type: assert property (
    st.vec_ok && st.vec[4:2] == `PRTD_VEC_SHORT |-> st.vec[1:0] == 2'b00)
    else $error("short vector wrong type");
  chk_frag_hold: assert property (
    $fell(st.frag_live) |-> $past(st.frag_cnt) == 34'(FRAG_CYCLES - 64'h1))
    else $error("fragment state dropped early");
  chk_bus_resp: assert property ((st.aw_hold && st.w_hold) |=> st.bvalid)
    else $error("write response missing");
  chk_read_answer: assert property ((s_axi_arvalid && st.arrdy) |=> st.rvalid)
    else $error("read answer missing");
endmodule
`default_nettype wire

// ### rtl/prtd_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PRTD_DEFS_SVH
`define PRTD_DEFS_SVH
// Register byte offsets
`define PRTD_REG_CTRL     8'h00
`define PRTD_REG_WORD     8'h04
`define PRTD_REG_VECTOR   8'h08
`define PRTD_REG_TIME     8'h0C
`define PRTD_REG_ZONE     8'h10
`define PRTD_REG_CHAR     8'h14
`define PRTD_REG_STATUS   8'h18
`define PRTD_REG_FRAG     8'h1C
// Control fields
`define PRTD_CTRL_ANYPH   0
`define PRTD_CTRL_ALTNUM  1
`define PRTD_CTRL_RATE_LO 2
`define PRTD_CTRL_FRAG    4
`define PRTD_CTRL_RESET   32'h0000_0000
// Info word fields
`define PRTD_TYPE_DATE    3'h1
`define PRTD_TYPE_TIME    3'h2
`define PRTD_TYPE_SYS     3'h5
`define PRTD_SYS_MARK     3'h2
// Vector codes
`define PRTD_VEC_INSTR    3'h1
`define PRTD_VEC_SHORT    3'h2
`define PRTD_VEC_NUM      3'h3
`define PRTD_VEC_NUMSP    3'h4
`define PRTD_VEC_ALPHA    3'h5
`define PRTD_VEC_NUMNS    3'h7
// Fragment hold time
`define PRTD_FRAG_MIN     4
`define PRTD_CLK_HZ       40000000
// Four minutes of clocks overflows 32 bits, so the product is 64-bit
`define PRTD_FRAG_CYC     (64'(`PRTD_FRAG_MIN * 60) * 64'(`PRTD_CLK_HZ))
`endif

// ### rtl/prtd_pkg.sv
// Types shared by the decode block
package prtd_pkg;
  // Supported rate and modulation pairings
  typedef enum logic [1:0] {
    prtd_r1600_2 = 2'b00,
    prtd_r3200_2 = 2'b01,
    prtd_r3200_4 = 2'b10,
    prtd_r6400_4 = 2'b11
  } prtd_rate_e;
  // Bus write phase
  typedef enum logic [1:0] {
    prtd_w_idle = 2'b00,
    prtd_w_resp = 2'b01
  } prtd_wst_e;
endpackage

// ### rtl/prtd_char_rom.sv
// Registered 7-bit character attribute table
`timescale 1ns/10ps
`default_nettype none
module prtd_char_rom (
  // Clock
  input  wire logic       aclk,
  // Lookup
  input  wire logic [6:0] code,
  output logic      [7:0] glyph,
  output logic            is_ctrl
);
  // Registered read; control codes keep their code but take no space
  always_ff @(posedge aclk) begin
    glyph   <= {1'b0, code};
    is_ctrl <= (code[6:5] == 2'b00) || (code == 7'h7F);
  end
endmodule
`default_nettype wire

// ### dv/prtd_net_model.sv
// Far-side model: paging network frame timing, frame 0 sync edge
`timescale 1ns/10ps
`default_nettype none
module prtd_net_model (
  // Clock
  input  wire logic aclk,
  // Request one frame 0 start
  input  wire logic go,
  // Sync leading edge toward the decoder
  output logic      frame0_sync = 1'b0
);
  // Sends no addresses or message numbers, so the sender's address
  // reuse, numbering and retrieval duties do not apply
  logic [2:0] left = 3'h0;  // Cycles of sync still to show

  // Sync stands a few cycles, then drops low between frames
  always @(posedge aclk) begin
    if (go) begin
      // Bench loads time words before asking for frame 0
      left <= 3'h4;
      frame0_sync <= 1'b1;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end else begin
      frame0_sync <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### dv/prtd_decoder_bench.sv
// Bench: register access over AXI4-Lite and decode checks
`timescale 1ns/10ps
`default_nettype none
`include "prtd_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module prtd_decoder_bench;
  logic        aclk = 1'b0;
  logic        aresetn, go, frame0_sync;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, brsp, rrsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          bad_count, checks_done, n, i, k;
  // Zone codes and expected signed quarter-hour offsets
  logic [4:0]  zc [8] = '{5'h00, 5'h01, 5'h0C, 5'h0D,
                          5'h10, 5'h11, 5'h14, 5'h1F};
  logic [7:0]  zq [8] = '{8'h00, 8'h04, 8'h30, 8'h0E,
                          8'h80, 8'h17, 8'hF2, 8'hFC};
  // Vector and subtype pairs that must be accepted
  logic [4:0]  vt [4] = '{{`PRTD_VEC_NUM, 2'b00}, {`PRTD_VEC_SHORT, 2'b00},
                          {`PRTD_VEC_ALPHA, 2'b00}, {`PRTD_VEC_INSTR, 2'b00}};
  // Numeric glyphs, standard then alternate; spare code is skipped
  string       ct [2] = '{"0123456789?U -][", "0123456789AB CDE"};

  // Short fragment hold keeps the run brief
  prtd_decoder #(.FRAG_CYCLES(50)) prtd_decoder_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .frame0_sync
  );
  prtd_net_model prtd_net_model_inst (.aclk, .go, .frame0_sync);

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  // Verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A wait ran out of its bound
  task automatic hang();
    bad_count++;
    $display("FAIL t=%0t no answer", $time);
    close_out();
  endtask

  // One write; idle edge first so no signal is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int c;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (c = 0; c < 64; c++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        brsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (c == 64) hang();
  endtask

  // One read; data and response taken at the handshake edge
  task automatic rd(input logic [7:0] a);
    int c;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (c = 0; c < 64; c++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (c == 64) hang();
  endtask

  // Read and compare under a mask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
    rd(a);
    `CHK(rdat & m, e)
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    hang();
  end

  // Main sequence
  initial begin
    {aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`PRTD_REG_CTRL, 32'hFFFFFFFF, 32'h0);
    rdc(`PRTD_REG_STATUS, 32'h3, 32'h0);
    // Unmapped place: read refused, write ignored
    rd(8'h40);
    `CHK(rrsp, 2'b10)
    `CHK(rdat, 32'h0)
    wr(8'h40, 32'hFFFFFFFF);
    `CHK(brsp, 2'b00)
    $display("test reset_unmapped done");
    for (i = 0; i < 4; i++) begin
      wr(`PRTD_REG_CTRL, 32'(i) << 2);
      rdc(`PRTD_REG_CTRL, 32'hC, 32'(i) << 2);
    end
    wr(`PRTD_REG_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(`PRTD_REG_VECTOR, {27'h0, vt[i]});
      rdc(`PRTD_REG_VECTOR, 32'h20, 32'h20);
    end
    wr(`PRTD_REG_VECTOR, {27'h0, `PRTD_VEC_SHORT, 2'b01});
    rdc(`PRTD_REG_VECTOR, 32'h20, 32'h0);
    wr(`PRTD_REG_VECTOR, {27'h0, `PRTD_VEC_INSTR, 2'b00});
    wr(`PRTD_REG_CTRL, 32'h0);
    rdc(`PRTD_REG_VECTOR, 32'h20, 32'h0);
    $display("test rate_vector done");
    // Coarse 3, minute 45, hour 17: held back until frame 0 sync
    wr(`PRTD_REG_WORD, {15'h0, 3'b010, 3'd3, 6'd45, 5'd17});
    rdc(`PRTD_REG_STATUS, 32'h3, 32'h2);
    rdc(`PRTD_REG_TIME, 32'h3F1F, 32'h0);
    rdc(`PRTD_REG_WORD, 32'h1FFFF, 32'h0000_9DB1);
    // System words: fine seconds 5, daylight saving set, marker 010
    for (i = 0; i < 8; i++) begin
      wr(`PRTD_REG_WORD, {15'h0, 3'b101, 3'd5, 2'b01, zc[i], 4'b0100});
      rdc(`PRTD_REG_ZONE, 32'hFF5F, {16'h0, zq[i], 3'b010, zc[i]});
    end
    rdc(`PRTD_REG_ZONE, 32'h80, 32'h80);
    wr(`PRTD_REG_WORD, {15'h0, 3'b101, 3'd5, 2'b01, 5'h01, 4'b0000});
    rdc(`PRTD_REG_ZONE, 32'h80, 32'h0);
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (n = 0; n < 20; n++) begin
      rd(`PRTD_REG_STATUS);
      if (rdat[0] === 1'b1) break;
    end
    `CHK(rdat[0], 1'b1)
    // Committed: valid, seconds 3 * 8 + 5 sixty-fourths, 45 min, 17 h
    rdc(`PRTD_REG_TIME, 32'h013F3F1F, 32'h011D2D11);
    // A date word neither pends nor touches the time
    wr(`PRTD_REG_WORD, {15'h0, 3'b001, 14'h3FFF});
    rdc(`PRTD_REG_STATUS, 32'h2, 32'h0);
    rdc(`PRTD_REG_TIME, 32'h3F1F, 32'h2D11);
    $display("test time_words done");
    for (i = 0; i < 2; i++) begin
      wr(`PRTD_REG_CTRL, 32'(i) << 1);
      for (k = 0; k < 16; k++) begin
        if (i == 1 || k != 10) begin
          wr(`PRTD_REG_CHAR, 32'(k));
          rdc(`PRTD_REG_CHAR, 32'hFF, {24'h0, ct[i][k]});
        end
      end
    end
    wr(`PRTD_REG_CHAR, 32'h0300);
    rdc(`PRTD_REG_CHAR, 32'h1FF00, 32'h10300);
    wr(`PRTD_REG_CHAR, 32'h3500);
    rdc(`PRTD_REG_CHAR, 32'h1FF00, 32'h03500);
    $display("test characters done");
    // Fragment state held for the hold time, renewed by a fresh fragment
    wr(`PRTD_REG_CTRL, 32'h10);
    rdc(`PRTD_REG_CTRL, 32'h20, 32'h20);
    repeat (38) @(posedge aclk);
    rdc(`PRTD_REG_CTRL, 32'h20, 32'h20);
    wr(`PRTD_REG_CTRL, 32'h10);
    repeat (40) @(posedge aclk);
    rdc(`PRTD_REG_CTRL, 32'h20, 32'h20);
    repeat (10) @(posedge aclk);
    rdc(`PRTD_REG_CTRL, 32'h20, 32'h0);
    $display("test fragment done");
    close_out();
  end
endmodule
`default_nettype wire
